//--- hw/asr_host.sv
// Host controller for a 512K x 8 asynchronous SRAM: one read or write per request.
// Assumes a 200 MHz clock and the SRAM wired directly to the pin ports.
// Function
// - Host presents all 19 address bits for every access.
// - Late control edges shift data validity to that control edge.
// - Host samples data only after the full access time elapsed.
// - Host keeps each read cycle at least the access time long.
// - Host deasserts a strobe while the address changes between writes.
`timescale 1ns/1ps
module asr_host
  import asr_pkg::*;
(
  // Clock and reset.
  input  wire logic              clock,
  input  wire logic              rst_n,
  // Request port.
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output      logic              req_ready,
  // Answer port.
  output      logic              rsp_valid,
  output      logic [DATA_W-1:0] rsp_rdata,
  // SRAM pins.
  output      logic [ADDR_W-1:0] addr_bus,
  output      logic              chip_select_n,
  output      logic              output_drive_n,
  output      logic              write_strobe_n,
  output      logic [DATA_W-1:0] data_bus_out,
  output      logic              data_bus_oe,
  input  wire logic [DATA_W-1:0] data_bus_in
);

  // The pin stage adds one cycle of output delay and three of input delay.
  localparam int               SYNC_LAT = 4;
  localparam logic [CNT_W-1:0] READ_LAST  = CNT_W'(READ_CYCLES + SYNC_LAT - 1);
  localparam logic [CNT_W-1:0] WRITE_LAST = CNT_W'(WRITE_CYCLES - 1);
  localparam logic [CNT_W-1:0] FLOAT_LAST = CNT_W'(FLOAT_CYCLES);

  asr_pins_if pins ();

  asr_state_t        state;
  asr_state_t        next_state;
  logic [CNT_W-1:0]  count;
  logic [CNT_W-1:0]  next_count;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              accept;
  logic              count_done;
  logic [CNT_W-1:0]  last_for;

  assign req_ready  = (state == ASR_IDLE);
  assign accept     = req_valid && req_ready;
  assign last_for   = (state == ASR_READ) ? READ_LAST : (state == ASR_WRITE) ? WRITE_LAST : FLOAT_LAST;
  assign count_done = (count == last_for);

  always_comb
  begin
    next_state = state;
    next_count = count + CNT_W'(1);
    case (state)
      ASR_IDLE:
      begin
        next_count = CNT_RESET;
        if (accept)
          next_state = req_write ? ASR_WRITE : ASR_READ;
      end
      ASR_READ:
        if (count_done)
        begin
          next_state = ASR_FLOAT;
          next_count = CNT_RESET;
        end
      ASR_WRITE:
        if (count_done)
        begin
          next_state = ASR_FLOAT;
          next_count = CNT_RESET;
        end
      ASR_FLOAT:
        if (count_done)
          next_state = ASR_IDLE;
      default:
        next_state = ASR_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state <= ASR_IDLE;
      count <= CNT_RESET;
      addr  <= '0;
      wdata <= '0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      if (accept)
      begin
        addr  <= req_addr;
        wdata <= req_wdata;
      end
    end
  end

  // Address is held through the float tail, so it never moves while a strobe is low.
  assign pins.addr  = addr;
  assign pins.cs_n  = !((state == ASR_READ) || (state == ASR_WRITE));
  assign pins.oe_n  = !(state == ASR_READ);
  assign pins.we_n  = !(state == ASR_WRITE);
  // Drive waits past the SRAM's own release after a read or a falling write strobe.
  assign pins.drive = (state == ASR_WRITE) && (count >= CNT_W'(WFLOAT_CYCLES));
  assign pins.wdata = wdata;

  // Data is sampled only at the end of the full access time plus the input delay.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end
    else
    begin
      rsp_valid <= (state == ASR_READ) && count_done;
      if ((state == ASR_READ) && count_done)
        rsp_rdata <= pins.rdata_sync;
    end
  end

  asr_pin_stage u_pins
  (
    .clock          (clock),
    .rst_n          (rst_n),
    .core           (pins.pins),
    .addr_bus       (addr_bus),
    .chip_select_n  (chip_select_n),
    .output_drive_n (output_drive_n),
    .write_strobe_n (write_strobe_n),
    .data_bus_out   (data_bus_out),
    .data_bus_oe    (data_bus_oe),
    .data_bus_in    (data_bus_in)
  );

  sequence s_read_start;
    accept && !req_write;
  endsequence

  sequence s_write_start;
    accept && req_write;
  endsequence

  a_read_answer_time: assert property (@(posedge clock) disable iff (!rst_n)
    s_read_start |-> ##16 rsp_valid)
    else $error("read answer not after full access time");

  a_read_strobes_low: assert property (@(posedge clock) disable iff (!rst_n)
    s_read_start |-> ##2 (!chip_select_n && !output_drive_n && write_strobe_n) [*8])
    else $error("read strobes not held");

  a_write_pulse_len: assert property (@(posedge clock) disable iff (!rst_n)
    s_write_start |-> ##3 (!write_strobe_n && !chip_select_n) [*8] ##1 write_strobe_n)
    else $error("write pulse length wrong");

  a_no_drive_on_read: assert property (@(posedge clock) disable iff (!rst_n)
    !output_drive_n |-> !data_bus_oe)
    else $error("bus contention on read");

  a_addr_stable_strobe: assert property (@(posedge clock) disable iff (!rst_n)
    (!chip_select_n && !$past(chip_select_n)) |-> $stable(addr_bus))
    else $error("address moved under a strobe");

  a_float_before_next: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(chip_select_n) |-> chip_select_n [*4])
    else $error("no float gap after access");

  a_drive_ends_with_we: assert property (@(posedge clock) disable iff (!rst_n)
    data_bus_oe |-> !write_strobe_n)
    else $error("data driven outside write");

  a_deselect_idle: assert property (@(posedge clock) disable iff (!rst_n)
    (req_ready && !req_valid) |-> ##2 chip_select_n)
    else $error("selected while idle");

endmodule : asr_host

//--- hw/asr_pkg.sv
// Package for the asynchronous SRAM host controller: pin widths, timing figures and cycle counts.
// Assumes a single 200 MHz clock domain in the controller.
package asr_pkg;

  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_PS = 5000;

  // Faster grade timing figures in picoseconds.
  localparam int ADDRESS_ACCESS_TIME_PS       = 55000;
  localparam int OUTPUT_ENABLE_ACCESS_TIME_PS = 25000;
  localparam int OUTPUT_DISABLE_TO_FLOAT_PS   = 20000;
  localparam int WRITE_PULSE_TIME_PS          = 45000;
  localparam int DATA_SETUP_TIME_PS           = 25000;
  localparam int WRITE_LOW_TO_FLOAT_PS        = 20000;

  // Least times round up to whole cycles.
  localparam int READ_CYCLES  = (ADDRESS_ACCESS_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FLOAT_CYCLES = (OUTPUT_DISABLE_TO_FLOAT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WRITE_CYCLES = (WRITE_PULSE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WFLOAT_CYCLES = (WRITE_LOW_TO_FLOAT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 4;

  localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;

  typedef enum logic [2:0]
  {
    ASR_IDLE  = 3'b000,
    ASR_READ  = 3'b001,
    ASR_WRITE = 3'b010,
    ASR_FLOAT = 3'b011
  } asr_state_t;

endpackage : asr_pkg

//--- hw/asr_pins_if.sv
// Interface between the controller core and its pin stage.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface asr_pins_if;
  import asr_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic              cs_n;
  logic              oe_n;
  logic              we_n;
  logic [DATA_W-1:0] wdata;
  logic              drive;
  logic [DATA_W-1:0] rdata_sync;
  modport core (output addr, cs_n, oe_n, we_n, wdata, drive, input rdata_sync);
  modport pins (input addr, cs_n, oe_n, we_n, wdata, drive, output rdata_sync);
endinterface : asr_pins_if

//--- hw/asr_pin_stage.sv
// Pin stage: registers the strobes and address, and synchronises the data bus input.
// Assumes the SRAM pins attach directly to these ports.
`timescale 1ns/1ps
module asr_pin_stage
  import asr_pkg::*;
(
  // Clock and reset.
  input  wire logic              clock,
  input  wire logic              rst_n,
  // Core side.
  asr_pins_if.pins               core,
  // SRAM pins.
  output      logic [ADDR_W-1:0] addr_bus,
  output      logic              chip_select_n,
  output      logic              output_drive_n,
  output      logic              write_strobe_n,
  output      logic [DATA_W-1:0] data_bus_out,
  output      logic              data_bus_oe,
  input  wire logic [DATA_W-1:0] data_bus_in
);

  logic [DATA_W-1:0] sync1;
  logic [DATA_W-1:0] sync2;
  logic [DATA_W-1:0] sync3;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      addr_bus       <= '0;
      chip_select_n  <= 1'b1;
      output_drive_n <= 1'b1;
      write_strobe_n <= 1'b1;
      data_bus_out   <= '0;
      data_bus_oe    <= 1'b0;
      sync1          <= '0;
      sync2          <= '0;
      sync3          <= '0;
    end
    else
    begin
      addr_bus       <= core.addr;
      chip_select_n  <= core.cs_n;
      output_drive_n <= core.oe_n;
      write_strobe_n <= core.we_n;
      data_bus_out   <= core.wdata;
      data_bus_oe    <= core.drive;
      sync1          <= data_bus_in;
      sync2          <= sync1;
      sync3          <= sync2;
    end
  end

  // The core samples the third stage once the full access time has passed and the bus has settled, so the last two stages already agree.
  assign core.rdata_sync = sync3;

endmodule : asr_pin_stage

//--- bench/asr_sram_model.sv
// Behavioural model of the asynchronous SRAM at its pins, faster grade.
// Assumes the bench resolves the shared data bus from both drivers.
`timescale 1ns/1ps
module asr_sram_model
  import asr_pkg::*;
(
  // SRAM pins.
  input  wire logic [ADDR_W-1:0] addr_bus,
  input  wire logic              chip_select_n,
  input  wire logic              output_drive_n,
  input  wire logic              write_strobe_n,
  input  wire logic [DATA_W-1:0] data_bus,
  // Model drive of the data bus.
  output      logic [DATA_W-1:0] q,
  output      logic              q_oe
);
  logic    [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic                 wr_act = 1'b0;
  logic    [DATA_W-1:0] wlatch = '0;
  realtime              t_addr = 0;
  realtime              t_cs   = 0;
  realtime              t_oe   = 0;
  wire                  read_mode = !chip_select_n && !output_drive_n && write_strobe_n;

  initial q = 8'h00;
  always @(addr_bus) t_addr = $realtime;
  always @(negedge chip_select_n) t_cs = $realtime;
  always @(negedge output_drive_n) t_oe = $realtime;

  // A write lands on whichever strobe rises first.
  always @(chip_select_n or write_strobe_n)
  begin
    if (wr_act && (chip_select_n || write_strobe_n))
      mem[addr_bus] = wlatch;
    wr_act = !chip_select_n && !write_strobe_n;
  end

  // No clock in the part, so the pins are polled each ns; data turns valid 1 ns early at most.
  always #1
  begin
    q_oe = read_mode;
    // The host may release the bus on the edge that ends the write, so the byte is latched while both strobes are low.
    if (!chip_select_n && !write_strobe_n)
      wlatch = data_bus;
    if (read_mode && $realtime - t_addr >= 54 && $realtime - t_cs >= 54 && $realtime - t_oe >= 24)
      q = mem[addr_bus];
    else if ($realtime - t_addr >= 5)
      q = ~q;
  end
endmodule : asr_sram_model

//--- bench/async_sram_read_port_bench.sv
// Self-checking bench for the SRAM host controller with an SRAM model on its pins.
// Assumes the design's own assertions guard the pin timing cycle by cycle.
`timescale 1ns/1ps
module async_sram_read_port_bench;
  import asr_pkg::*;
  logic              clock = 1'b0;
  logic              rst_n = 1'b0;
  logic              req_valid = 1'b0;
  logic              req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = '0;
  logic              req_ready, rsp_valid, chip_select_n, output_drive_n, write_strobe_n, data_bus_oe, q_oe;
  logic [DATA_W-1:0] rsp_rdata, data_bus_out, q;
  logic [ADDR_W-1:0] addr_bus;
  logic [ADDR_W-1:0] last_addr = '0;
  logic              last_cs = 1'b1;
  int                errors = 0;
  int                n_compared = 0;
  // The bus floats to a changing pattern when nobody drives it.
  wire  [DATA_W-1:0] data_bus = data_bus_oe ? data_bus_out : q;

  always #2.5 clock = ~clock;

  asr_host uut (.clock(clock), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .addr_bus(addr_bus), .chip_select_n(chip_select_n),
    .output_drive_n(output_drive_n), .write_strobe_n(write_strobe_n), .data_bus_out(data_bus_out),
    .data_bus_oe(data_bus_oe), .data_bus_in(data_bus));
  asr_sram_model sram (.addr_bus(addr_bus), .chip_select_n(chip_select_n), .output_drive_n(output_drive_n),
    .write_strobe_n(write_strobe_n), .data_bus(data_bus), .q(q), .q_oe(q_oe));

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic end_of_test();
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // Request stays up while refused and drops after the taking edge.
  task automatic issue(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(negedge clock);
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    while (req_ready !== 1'b1)
    begin
      @(negedge clock);
      n++;
      if (n > 60)
      begin
        errors++;
        end_of_test();
      end
    end
    @(negedge clock);
    req_valid = 1'b0;
  endtask : issue

  task automatic do_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    int n;
    int low;
    n = 0;
    low = 0;
    issue(1'b0, a, 8'h00);
    while (rsp_valid !== 1'b1 && n < 40)
    begin
      @(negedge clock);
      n++;
      low += (chip_select_n === 1'b0);
    end
    if (n == 40)
    begin
      errors++;
      end_of_test();
    end
    chk_val(32'(n), 32'd15);
    chk_val(32'(low >= 11), 32'd1);
    chk_val({24'h0, rsp_rdata}, {24'h0, exp});
  endtask : do_read

  // Pin watch: no contention, address frozen while selected.
  always @(negedge clock)
  begin
    if (rst_n === 1'b1)
    begin
      chk_val({31'h0, q_oe & data_bus_oe}, 32'h0);
      if (chip_select_n === 1'b0 && last_cs === 1'b0)
        chk_val({13'h0, addr_bus}, {13'h0, last_addr});
    end
    last_addr <= addr_bus;
    last_cs <= chip_select_n;
  end

  task automatic t_corners();
    issue(1'b1, 19'h0_0000, 8'h5A);
    issue(1'b1, 19'h7_FFFF, 8'hA5);
    issue(1'b1, 19'h5_5555, 8'hFF);
    do_read(19'h0_0000, 8'h5A);
    do_read(19'h7_FFFF, 8'hA5);
    do_read(19'h5_5555, 8'hFF);
  endtask : t_corners

  task automatic t_overwrite();
    issue(1'b1, 19'h2_AAAA, 8'h00);
    do_read(19'h2_AAAA, 8'h00);
    issue(1'b1, 19'h2_AAAA, 8'hC3);
    do_read(19'h2_AAAA, 8'hC3);
  endtask : t_overwrite

  // A reset mid-read must deselect at once and leave the array intact.
  task automatic t_reset_mid();
    issue(1'b0, 19'h7_FFFF, 8'h00);
    repeat (5) @(negedge clock);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    chk_val({28'h0, chip_select_n, output_drive_n, write_strobe_n, data_bus_oe}, 32'hE);
    chk_val({30'h0, req_ready, rsp_valid}, 32'h2);
    rst_n = 1'b1;
    @(negedge clock);
    do_read(19'h7_FFFF, 8'hA5);
  endtask : t_reset_mid

  initial
  begin
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    t_corners();
    t_overwrite();
    t_reset_mid();
    end_of_test();
  end
endmodule : async_sram_read_port_bench
